// file: verilog/seo_pkg.sv
// shared constants and types of the supply-enable output select block
`default_nettype none
package seo_pkg;
   localparam int unsigned SEO_PINS     = 12;
   localparam int unsigned SEO_CHANNELS = 16;
   localparam int unsigned SEO_PAGE_W   = 4;
   // register offset of the output pin function word
   localparam logic [7:0]  SEO_CFG_OFFSET = 8'hd2;
   // field positions
   localparam int unsigned SEO_FUNC_LSB  = 0;
   localparam int unsigned SEO_POL_BIT   = 6;
   localparam int unsigned SEO_DRIVE_BIT = 7;
   localparam int unsigned SEO_MASK_LSB  = 16;
   // bits that exist; all others read zero
   localparam logic [31:0] SEO_WRITE_MASK = 32'hffff_00c7;
   localparam logic [31:0] SEO_CFG_RESET  = 32'h0000_0000;
   // pages that carry special functions
   localparam logic [3:0]  SEO_PAGE_SECOND_FAULT_LINE = 4'ha;
   localparam logic [3:0]  SEO_PAGE_SEQ    = 4'hb;
   // delay counter width
   localparam int unsigned SEO_DLY_W = 16;
   localparam logic [15:0] SEO_DLY_RESET = 16'h0000;

   typedef enum logic [2:0] {
      SEO_FN_SUPPLY   = 3'h0,
      SEO_FN_FORCE_ON = 3'h1,
      SEO_FN_FORCE_OFF= 3'h2,
      SEO_FN_AND_GOOD = 3'h3,
      SEO_FN_OR_ALARM = 3'h4,
      SEO_FN_SPECIAL  = 3'h5
   } seo_func_t;

   typedef struct packed {
      logic [15:0] mask;
      logic [7:0]  zeroHi;
      logic        driveOpen;
      logic        polHigh;
      logic [2:0]  zeroLo;
      logic [2:0]  func;
   } seo_cfg_t;

   typedef struct packed {
      logic             wrEn;
      logic [7:0]       cmd;
      logic [3:0]       page;
      logic [31:0]      data;
   } seo_wr_t;
endpackage : seo_pkg
`default_nettype wire

// file: verilog/seo_output_select.sv
// output function logic of the twelve supply-enable / general outputs
// ****************************************************************
// What this block does
// - polarity_sel picks asserted level, 1 means high
// - drive_type_sel picks push-pull or open-drain
// - function_sel picks enable, force on, force off
// - code 011 ANDs masked power-good inputs
// - code 100 ORs masked channel alarms
// - mask bit N+16 is channel N
// - alarm per channel comes from fault response
// - code 101 special on pages 10, 11
// - bits 15:8 and 5:3 read zero
// - output changes after input steady through delay
// ****************************************************************
`timescale 1ns/10ps
`default_nettype none
module seo_output_select
   import seo_pkg::*;
(
   input  wire logic                      ref_clk,
   input  wire logic                      rstn,
   input  wire seo_wr_t                   cfgWrite,
   input  wire logic [SEO_PAGE_W-1:0]     rdPage,
   input  wire logic [SEO_PINS-1:0]       supplyEnable,
   input  wire logic [SEO_CHANNELS-1:0]   goodInput,
   input  wire logic [SEO_CHANNELS-1:0]   channelAlarm,
   input  wire logic                      secondFaultFunc,
   input  wire logic                      sequenceLineFunc,
   input  wire logic [SEO_DLY_W-1:0]      onDelay,
   input  wire logic [SEO_DLY_W-1:0]      offDelay,
   output logic [31:0]                    rdData,
   output logic [SEO_PINS-1:0]            supplyEnableOut,
   output logic [SEO_PINS-1:0]            supplyEnableOe
);
   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   logic [SEO_CHANNELS-1:0] goodMeta, goodSync, alarmMeta, alarmSync;
   logic [SEO_PINS-1:0]     enMeta, enSync;
   logic [1:0]              specMeta, specSync;

   // these pins are not timed to ref_clk, so two stages each
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         goodMeta <= '0;
         goodSync <= '0;
      end else begin
         goodMeta <= goodInput;
         goodSync <= goodMeta;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         alarmMeta <= '0;
         alarmSync <= '0;
      end else begin
         alarmMeta <= channelAlarm;
         alarmSync <= alarmMeta;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         enMeta <= '0;
         enSync <= '0;
      end else begin
         enMeta <= supplyEnable;
         enSync <= enMeta;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         specMeta <= '0;
         specSync <= '0;
      end else begin
         specMeta <= {sequenceLineFunc, secondFaultFunc};
         specSync <= specMeta;
      end
   end

   // ****************************************************************
   // configuration words, one per page 0 to 11
   // ****************************************************************
   seo_cfg_t cfg [SEO_PINS];

   // pages twelve and up hold no word: writes drop, reads give zero
   function automatic logic pageOk(input logic [SEO_PAGE_W-1:0] p);
      return p < SEO_PAGE_W'(SEO_PINS);
   endfunction : pageOk

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         for (int i = 0; i < SEO_PINS; i++) begin
            cfg[i] <= seo_cfg_t'(SEO_CFG_RESET);
         end
      end else if (cfgWrite.wrEn && cfgWrite.cmd == SEO_CFG_OFFSET
                   && pageOk(cfgWrite.page)) begin
         // unused bits never stored, so they read zero
         cfg[cfgWrite.page] <=
            seo_cfg_t'(cfgWrite.data & SEO_WRITE_MASK);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         rdData <= '0;
      end else if (pageOk(rdPage)) begin
         rdData <= cfg[rdPage] & SEO_WRITE_MASK;
      end else begin
         rdData <= '0;
      end
   end

   // ****************************************************************
   // function select
   // ****************************************************************
   function automatic logic pinFunc(input seo_cfg_t c, input int pin,
                                    input logic en,
                                    input logic [15:0] good,
                                    input logic [15:0] alarm,
                                    input logic [1:0]  spec);
      logic r;
      r = 1'b0;
      case (c.func)
         SEO_FN_SUPPLY:    r = en;
         SEO_FN_FORCE_ON:  r = 1'b1;
         SEO_FN_FORCE_OFF: r = 1'b0;
         // cleared mask bits count as true in the AND
         SEO_FN_AND_GOOD:  r = &(good | ~c.mask);
         SEO_FN_OR_ALARM:  r = |(alarm & c.mask);
         SEO_FN_SPECIAL: begin
            if (pin == int'(SEO_PAGE_SECOND_FAULT_LINE)) begin
               r = spec[0];
            end else if (pin == int'(SEO_PAGE_SEQ)) begin
               r = spec[1];
            end else begin
               r = 1'b0;
            end
         end
         default:          r = 1'b0; // reserved codes stay deasserted
      endcase
      return r;
   endfunction : pinFunc

   logic [SEO_PINS-1:0] rawAssert;
   always_comb begin
      for (int i = 0; i < SEO_PINS; i++) begin
         rawAssert[i] = pinFunc(cfg[i], i, enSync[i], goodSync, alarmSync,
                                specSync);
      end
   end

   // ****************************************************************
   // on/off delay filter
   // ****************************************************************
   // input must stay steady for the whole delay; any change restarts it
   logic [SEO_PINS-1:0]  filtered, lastRaw;
   logic [SEO_DLY_W-1:0] dlyCnt [SEO_PINS];

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         lastRaw <= '0;
      end else begin
         lastRaw <= rawAssert;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         filtered <= '0;
         for (int i = 0; i < SEO_PINS; i++) begin
            dlyCnt[i] <= SEO_DLY_RESET;
         end
      end else begin
         for (int i = 0; i < SEO_PINS; i++) begin
            if (rawAssert[i] != lastRaw[i]) begin
               dlyCnt[i] <= SEO_DLY_RESET;
            end else if (rawAssert[i] != filtered[i]) begin
               if (dlyCnt[i] >= (rawAssert[i] ? onDelay : offDelay)) begin
                  filtered[i] <= rawAssert[i];
                  dlyCnt[i]   <= SEO_DLY_RESET;
               end else begin
                  dlyCnt[i] <= dlyCnt[i] + SEO_DLY_W'(1);
               end
            end else begin
               dlyCnt[i] <= SEO_DLY_RESET;
            end
         end
      end
   end

   // ****************************************************************
   // pin drivers
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         supplyEnableOut <= '0;
      end else begin
         for (int i = 0; i < SEO_PINS; i++) begin
            if (cfg[i].driveOpen) begin
               // open drain never drives high; the pull-up does
               supplyEnableOut[i] <= 1'b0;
            end else begin
               // asserted gives the active level, deasserted its inverse
               supplyEnableOut[i] <= filtered[i] ~^ cfg[i].polHigh;
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         supplyEnableOe <= '0;
      end else begin
         for (int i = 0; i < SEO_PINS; i++) begin
            if (cfg[i].driveOpen) begin
               // open drain: pull low only when the low level is wanted
               supplyEnableOe[i] <= (filtered[i] == ~cfg[i].polHigh);
            end else begin
               supplyEnableOe[i] <= 1'b1;
            end
         end
      end
   end
endmodule : seo_output_select
`default_nettype wire

// file: test/seo_pin_model.sv
// far-side wires of the twelve outputs, each with a pull-up
`timescale 1ns/10ps
`default_nettype none
module seo_pin_model
   import seo_pkg::*;
(
   input  wire logic [SEO_PINS-1:0] pinOut,
   input  wire logic [SEO_PINS-1:0] pinOe,
   output logic      [SEO_PINS-1:0] pinLevel
);
   // released lines float to the pull-up level
   assign pinLevel = pinOut & pinOe | ~pinOe;
endmodule : seo_pin_model
`default_nettype wire

// file: test/seo_output_select_checker.sv
// port assertions of the output select block
`timescale 1ns/10ps
`default_nettype none
module seo_output_select_checker
   import seo_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rstn,
   input wire seo_wr_t     cfgWrite,
   input wire logic [3:0]  rdPage,
   input wire logic [11:0] supplyEnable,
   input wire logic [15:0] goodInput,
   input wire logic [15:0] channelAlarm,
   input wire logic [15:0] onDelay,
   input wire logic [15:0] offDelay,
   input wire logic [31:0] rdData,
   input wire logic [11:0] supplyEnableOut,
   input wire logic [11:0] supplyEnableOe
);
   logic [31:0] shd [12];
   logic [31:0] rdExp, shdQ;
   logic        z, okA, okD, e, o;
   seo_cfg_t    c;
   always_ff @(posedge ref_clk) begin
      shdQ <= shd[0];
      if (!rstn)
         shd <= '{default: 32'h0};
      else if (cfgWrite.wrEn && cfgWrite.cmd == 8'hd2 && cfgWrite.page < 12)
         shd[cfgWrite.page] <= cfgWrite.data & SEO_WRITE_MASK;
   end
   assign rdExp = rdPage < 12 ? shd[rdPage] : 32'h0;
   assign c = shd[0];
   // pin checks only hold once the word sits still and both delays are zero
   assign z = onDelay == 16'h0 && offDelay == 16'h0 && shdQ == shd[0];
   assign e = supplyEnableOe[0];
   assign o = supplyEnableOut[0];
   assign okA = c.driveOpen ? e != c.polHigh && !o : e && o == c.polHigh;
   assign okD = c.driveOpen ? e == c.polHigh && !o : e && o != c.polHigh;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   a_rd_word: assert property (1 |=> rdData == $past(rdExp))
      else $error("read word wrong");
   a_zero_bits: assert property (rdData[15:8] == 0 && rdData[5:3] == 0)
      else $error("unused bits set");
   a_follow_en: assert property ((c.func == 3'h0 && z &&
      $stable(supplyEnable[0]))[*8] |-> (supplyEnable[0] ? okA : okD))
      else $error("enable not followed");
   a_force_on: assert property ((c.func == 3'h1 && z)[*8] |-> okA)
      else $error("force on wrong");
   a_force_off: assert property ((c.func == 3'h2 && z)[*8] |-> okD)
      else $error("force off wrong");
   a_and_good: assert property ((c.func == 3'h3 && z &&
      $stable(goodInput))[*8] |-> (&(goodInput | ~c.mask) ? okA : okD))
      else $error("and wrong");
   a_or_alarm: assert property ((c.func == 3'h4 && z &&
      $stable(channelAlarm))[*8] |-> (|(channelAlarm & c.mask) ? okA : okD))
      else $error("or wrong");
   a_reserved_off: assert property ((c.func > 3'h4 && z)[*8] |-> okD)
      else $error("reserved asserts");
   cover property (c.func == 3'h3 && okA);
   cover property (c.func == 3'h4 && okA);
   cover property (c.func == 3'h1 && c.driveOpen && okA);
endmodule : seo_output_select_checker
`default_nettype wire

// file: test/tb_seo_output_select.sv
// self-checking bench of the output select block
`timescale 1ns/10ps
`default_nettype none
module tb_seo_output_select
   import seo_pkg::*;
;
   logic        ref_clk = 0, rstn = 0;
   logic        secondFaultFunc = 0, sequenceLineFunc = 0;
   seo_wr_t     cfgWrite = '0;
   logic [3:0]  rdPage = 4'h0;
   logic [11:0] supplyEnable = 12'h0;
   logic [11:0] supplyEnableOut, supplyEnableOe, pinLevel;
   logic [15:0] goodInput = 16'h0, channelAlarm = 16'h0;
   logic [15:0] onDelay = 16'h0, offDelay = 16'h0;
   logic [31:0] rdData;
   int          error_cnt = 0, cmp_count = 0;
   seo_output_select dut (
      .ref_clk         (ref_clk),
      .rstn            (rstn),
      .cfgWrite        (cfgWrite),
      .rdPage          (rdPage),
      .supplyEnable    (supplyEnable),
      .goodInput       (goodInput),
      .channelAlarm    (channelAlarm),
      .secondFaultFunc (secondFaultFunc),
      .sequenceLineFunc(sequenceLineFunc),
      .onDelay         (onDelay),
      .offDelay        (offDelay),
      .rdData          (rdData),
      .supplyEnableOut (supplyEnableOut),
      .supplyEnableOe  (supplyEnableOe)
   );
   seo_pin_model far (.pinOut(supplyEnableOut), .pinOe(supplyEnableOe),
      .pinLevel(pinLevel));
   always #12.5 ref_clk = ~ref_clk;
   task automatic cmp(input logic [31:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   task automatic wr(input logic [3:0] p, input logic [31:0] d,
                     input logic [7:0] m = 8'hd2);
      @(posedge ref_clk) cfgWrite <= '{1'b1, m, p, d};
      @(posedge ref_clk) cfgWrite.wrEn <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] p, input logic [31:0] x);
      @(posedge ref_clk) rdPage <= p;
      repeat (2) @(negedge ref_clk);
      cmp(rdData, x);
   endtask : rd
   // sync, filter and output stages settle well inside eight clocks
   task automatic pin(input int p, input logic x);
      repeat (8) @(negedge ref_clk);
      cmp(pinLevel[p], x);
   endtask : pin
   task automatic t_regs;
      wr(4'h0, 32'hffff_ffff);
      wr(4'h5, 32'h1234_5678);
      wr(4'hc, 32'hffff_ffff);
      wr(4'h1, 32'hffff_ffff, 8'hd3);
      rd(4'h0, 32'hffff_00c7);
      rd(4'h5, 32'h1234_0040);
      rd(4'h1, 32'h0);
      rd(4'hc, 32'h0);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_force;
      for (int i = 0; i < 8; i++) begin
         wr(4'h0, {24'h0, i[2:1], 4'h0, ~i[0], i[0]});
         pin(0, i[0] ~^ i[1]);
         cmp(supplyEnableOe[0], !i[2] || (i[0] ^ i[1]));
      end
      $display("t_force done");
   endtask : t_force
   task automatic t_supply;
      wr(4'h0, 32'h40);
      wr(4'h3, 32'h40);
      @(posedge ref_clk) supplyEnable <= 12'h009;
      pin(0, 1);
      cmp(pinLevel[3], 1);
      cmp(pinLevel[5], 0);
      @(posedge ref_clk) supplyEnable <= 12'h0;
      pin(0, 0);
      $display("t_supply done");
   endtask : t_supply
   task automatic t_logic;
      wr(4'h0, 32'h000a_0043);
      @(posedge ref_clk) goodInput <= 16'h000a;
      pin(0, 1);
      @(posedge ref_clk) goodInput <= 16'hfff7;
      pin(0, 0);
      wr(4'h0, 32'h0004_0044);
      @(posedge ref_clk) channelAlarm <= 16'hfffb;
      pin(0, 0);
      @(posedge ref_clk) channelAlarm <= 16'h0004;
      pin(0, 1);
      $display("t_logic done");
   endtask : t_logic
   task automatic t_special;
      wr(4'ha, 32'h45);
      wr(4'hb, 32'h45);
      @(posedge ref_clk) secondFaultFunc <= 1;
      pin(10, 1);
      cmp(pinLevel[11], 0);
      @(posedge ref_clk) {secondFaultFunc, sequenceLineFunc} <= 2'b01;
      pin(11, 1);
      cmp(pinLevel[10], 0);
      for (int f = 5; f < 8; f++) begin
         wr(4'h0, 32'h1);
         pin(0, 0);
         wr(4'h0, f);
         pin(0, 1);
      end
      $display("t_special done");
   endtask : t_special
   task automatic t_delay;
      wr(4'h1, 32'h40);
      @(posedge ref_clk) {onDelay, offDelay} <= {16'h14, 16'h28};
      @(posedge ref_clk) supplyEnable[1] <= 1;
      repeat (10) @(posedge ref_clk);
      supplyEnable[1] <= 0;
      repeat (3) pin(1, 0);
      @(posedge ref_clk) supplyEnable[1] <= 1;
      repeat (2) pin(1, 0);
      repeat (8) @(negedge ref_clk);
      pin(1, 1);
      // the longer off delay must keep the pin up after release
      @(posedge ref_clk) supplyEnable[1] <= 0;
      repeat (4) pin(1, 1);
      repeat (8) @(negedge ref_clk);
      pin(1, 0);
      $display("t_delay done");
   endtask : t_delay
   task automatic t_reset;
      @(posedge ref_clk) rstn <= 0;
      repeat (12) @(negedge ref_clk);
      cmp(supplyEnableOe, 12'h0);
      @(posedge ref_clk) rstn <= 1;
      rd(4'h5, 32'h0);
      cmp(pinLevel, 12'hfff);
      $display("t_reset done");
   endtask : t_reset
   initial begin
      repeat (12) @(posedge ref_clk);
      rstn <= 1;
      t_regs();
      t_force();
      t_supply();
      t_logic();
      t_special();
      t_delay();
      t_reset();
      print_verdict();
   end
endmodule : tb_seo_output_select
bind seo_output_select seo_output_select_checker chk (
   .ref_clk        (ref_clk),
   .rstn           (rstn),
   .cfgWrite       (cfgWrite),
   .rdPage         (rdPage),
   .supplyEnable   (supplyEnable),
   .goodInput      (goodInput),
   .channelAlarm   (channelAlarm),
   .onDelay        (onDelay),
   .offDelay       (offDelay),
   .rdData         (rdData),
   .supplyEnableOut(supplyEnableOut),
   .supplyEnableOe (supplyEnableOe)
);
`default_nettype wire
